// [rtl/ssirq_top.sv]
// sticky status interrupt registers for one quad and its four channels
`timescale 1ns/1ns
`include "ssirq_defs.svh"
module ssirq_top (
    input  wire logic                     clock_i,
    input  wire logic                     arst_n_i,
    input  wire ssirq_pkg::ssirq_status_t status_i,
    input  wire ssirq_pkg::ssirq_req_t    req_i,
    output logic [7:0]                    rdata_o,
    output logic                          rvalid_o,
    output logic                          irq_o
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------------------------------
    // status inputs come from other clock domains
    // ----------------------------------------------------------------
    ssirq_pkg::ssirq_status_t stat_meta;
    ssirq_pkg::ssirq_status_t stat;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            stat_meta <= '0;
            stat      <= '0;
        end else begin
            stat_meta <= status_i;
            stat      <= stat_meta;
        end
    end

    // msb-first numbering: documented bit n is vector bit 7-n
    function automatic logic [2:0] pos(input int unsigned n);
        pos = 3'(7 - n);
    endfunction

    // ----------------------------------------------------------------
    // enable registers
    // ----------------------------------------------------------------
    logic [7:0] align_en;
    logic [7:0] sync_en;
    logic [7:0] fifo_en [4];
    logic [7:0] next_align_en;
    logic [7:0] next_sync_en;
    logic [7:0] next_fifo_en [4];

    logic q_wr;
    logic c_wr;
    assign q_wr = req_i.wr && !req_i.chan_space;
    assign c_wr = req_i.wr && req_i.chan_space;

    always_comb begin
        next_align_en = align_en;
        next_sync_en  = sync_en;
        for (int c = 0; c < 4; c++) begin
            next_fifo_en[c] = fifo_en[c];
        end
        if (q_wr && req_i.addr == `SSIRQ_Q_ALIGN_EN) begin
            next_align_en = req_i.wdata;
        end
        if (q_wr && req_i.addr == `SSIRQ_Q_SYNC_EN) begin
            next_sync_en = req_i.wdata;
        end
        if (c_wr && req_i.addr == `SSIRQ_C_FIFO_EN) begin
            next_fifo_en[req_i.chan] = req_i.wdata;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            align_en <= `SSIRQ_RST_BYTE;
            sync_en  <= `SSIRQ_RST_BYTE;
            for (int c = 0; c < 4; c++) begin
                fifo_en[c] <= `SSIRQ_RST_BYTE;
            end
        end else begin
            align_en <= next_align_en;
            sync_en  <= next_sync_en;
            for (int c = 0; c < 4; c++) begin
                fifo_en[c] <= next_fifo_en[c];
            end
        end
    end

    // ----------------------------------------------------------------
    // read decode and sticky bits
    // ----------------------------------------------------------------
    logic q_rd;
    logic c_rd;
    assign q_rd = req_i.rd && !req_i.chan_space;
    assign c_rd = req_i.rd && req_i.chan_space;

    logic       rd_align;
    logic       rd_sync;
    logic [3:0] rd_fifo;
    assign rd_align = q_rd && req_i.addr == `SSIRQ_Q_ALIGN_LATCH;
    assign rd_sync  = q_rd && req_i.addr == `SSIRQ_Q_SYNC_LATCH;

    logic       align_lat;
    logic [3:0] sync_lat;
    logic [3:0] urun_lat;
    logic [3:0] orun_lat;

    ssirq_bit u_align (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n),
        .status_i   (stat.aligned),
        .enable_i   (align_en[pos(`SSIRQ_BIT_ALIGN)]),
        .read_clr_i (rd_align),
        .latch_o    (align_lat)
    );

    for (genvar c = 0; c < 4; c++) begin : g_ch
        assign rd_fifo[c] = c_rd && req_i.chan == 2'(c)
                            && req_i.addr == `SSIRQ_C_FIFO_LATCH;
        ssirq_bit u_sync (
            .clock_i    (clock_i),
            .rst_n_i    (rst_n),
            .status_i   (stat.link_sync[c]),
            .enable_i   (sync_en[pos(`SSIRQ_BIT_SYNC0 + c)]),
            .read_clr_i (rd_sync),
            .latch_o    (sync_lat[c])
        );
        ssirq_bit u_urun (
            .clock_i    (clock_i),
            .rst_n_i    (rst_n),
            .status_i   (stat.fifo_urun[c]),
            .enable_i   (fifo_en[c][pos(`SSIRQ_BIT_URUN)]),
            .read_clr_i (rd_fifo[c]),
            .latch_o    (urun_lat[c])
        );
        ssirq_bit u_orun (
            .clock_i    (clock_i),
            .rst_n_i    (rst_n),
            .status_i   (stat.fifo_orun[c]),
            .enable_i   (fifo_en[c][pos(`SSIRQ_BIT_ORUN)]),
            .read_clr_i (rd_fifo[c]),
            .latch_o    (orun_lat[c])
        );
    end

    // ----------------------------------------------------------------
    // read data mux, value returned before the clear lands
    // ----------------------------------------------------------------
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic       rvalid;
    always_comb begin
        next_rdata = 8'h00;
        if (q_rd) begin
            unique case (req_i.addr)
                `SSIRQ_Q_ALIGN_EN:    next_rdata = align_en;
                `SSIRQ_Q_SYNC_EN:     next_rdata = sync_en;
                `SSIRQ_Q_ALIGN_STAT:
                    next_rdata[pos(`SSIRQ_BIT_ALIGN)] = stat.aligned;
                `SSIRQ_Q_ALIGN_LATCH:
                    next_rdata[pos(`SSIRQ_BIT_ALIGN)] = align_lat;
                `SSIRQ_Q_SYNC_STAT:
                    next_rdata[3:0] = {stat.link_sync[0], stat.link_sync[1],
                                       stat.link_sync[2], stat.link_sync[3]};
                `SSIRQ_Q_SYNC_LATCH:
                    next_rdata[3:0] = {sync_lat[0], sync_lat[1],
                                       sync_lat[2], sync_lat[3]};
                default:              next_rdata = 8'h00;
            endcase
        end else if (c_rd) begin
            unique case (req_i.addr)
                `SSIRQ_C_FIFO_EN:     next_rdata = fifo_en[req_i.chan];
                `SSIRQ_C_FIFO_STAT:
                    next_rdata[1:0] = {stat.fifo_urun[req_i.chan],
                                       stat.fifo_orun[req_i.chan]};
                `SSIRQ_C_FIFO_LATCH:
                    next_rdata[1:0] = {urun_lat[req_i.chan],
                                       orun_lat[req_i.chan]};
                default:              next_rdata = 8'h00;
            endcase
        end
    end

    logic next_irq;
    logic irq;
    assign next_irq = align_lat || (|sync_lat) || (|urun_lat)
                      || (|orun_lat);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
            irq    <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            rvalid <= req_i.rd;
            irq    <= next_irq;
        end
    end

    assign rdata_o  = rdata;
    assign rvalid_o = rvalid;
    assign irq_o    = irq;
endmodule

// [include/ssirq_defs.svh]
// register offsets, bit positions and reset values of the status interrupt block
// What this block does
// - enabled high status sets its latched bit
// - latched bit stays high after status drops
// - reading a latch register clears its bits
// - status still high re-sets bit after read
// - any latched bit raises interrupt request
// - link sync: status 0x84, enable 0x1c, latch 0x85
// - alignment: status 0x82, enable 0x0c, latch 0x83
// - fifo under/overrun: bits 6,7 of 0x85/0x0a/0x8a
// - fifo flags are active-high per-channel inputs
// - link sync input high when channel synchronised
// - align input high when four channels aligned
// - bit 0 is msb, bit 7 is lsb
`ifndef SSIRQ_DEFS_SVH
`define SSIRQ_DEFS_SVH

// ----------------------------------------------------------------
// quad register space offsets
// ----------------------------------------------------------------
`define SSIRQ_Q_ALIGN_EN      8'h0c
`define SSIRQ_Q_SYNC_EN       8'h1c
`define SSIRQ_Q_ALIGN_STAT    8'h82
`define SSIRQ_Q_ALIGN_LATCH   8'h83
`define SSIRQ_Q_SYNC_STAT     8'h84
`define SSIRQ_Q_SYNC_LATCH    8'h85

// ----------------------------------------------------------------
// channel register space offsets
// ----------------------------------------------------------------
`define SSIRQ_C_FIFO_EN       8'h0a
`define SSIRQ_C_FIFO_STAT     8'h85
`define SSIRQ_C_FIFO_LATCH    8'h8a

// ----------------------------------------------------------------
// documented bit numbers, bit 0 being the msb
// ----------------------------------------------------------------
`define SSIRQ_BIT_ALIGN       2
`define SSIRQ_BIT_SYNC0       4
`define SSIRQ_BIT_URUN        6
`define SSIRQ_BIT_ORUN        7

`define SSIRQ_RST_BYTE        8'h00

`endif

// [include/ssirq_pkg.sv]
// types shared by the status interrupt block
package ssirq_pkg;

    typedef struct packed {
        logic [3:0] link_sync;
        logic       aligned;
        logic [3:0] fifo_urun;
        logic [3:0] fifo_orun;
    } ssirq_status_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       chan_space;
        logic [1:0] chan;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssirq_req_t;

endpackage

// [rtl/ssirq_bit.sv]
// one sticky status interrupt bit with enable and clear-on-read
`timescale 1ns/1ns
module ssirq_bit (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic status_i,
    input  wire logic enable_i,
    input  wire logic read_clr_i,
    output logic      latch_o
);
    logic latch;
    logic next_latch;

    // set beats the read clear so a live status re-arms at once
    always_comb begin
        next_latch = latch;
        if (read_clr_i) begin
            next_latch = 1'b0;
        end
        if (enable_i && status_i) begin
            next_latch = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch <= 1'b0;
        end else begin
            latch <= next_latch;
        end
    end

    assign latch_o = latch;
endmodule

// [testbench/ssirq_top_props.sv]
// port assertions for the status interrupt block
`timescale 1ns/1ns
module ssirq_top_props (
    input  wire logic                     clock_i,
    input  wire logic                     arst_n_i,
    input  wire ssirq_pkg::ssirq_status_t status_i,
    input  wire ssirq_pkg::ssirq_req_t    req_i,
    input  wire logic [7:0]               rdata_o,
    input  wire logic                     rvalid_o,
    input  wire logic                     irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------------------------------
    // read answer
    // ----------------------------------------------------------------
    a_read_answered: assert property (
        req_i.rd |=> rvalid_o) else $error("read not answered");
    a_no_spurious_valid: assert property (
        !req_i.rd |=> !rvalid_o) else $error("valid without read");
    a_write_silent: assert property (
        req_i.wr |=> !rvalid_o) else $error("write answered");
    a_idle_rdata: assert property (
        !rvalid_o |-> rdata_o == 8'h00) else $error("rdata not idle");
    a_unmapped_zero: assert property (
        req_i.rd && !(req_i.chan_space ?
        req_i.addr inside {8'h0a, 8'h85, 8'h8a} :
        req_i.addr inside {8'h0c, 8'h1c, 8'h82, 8'h83, 8'h84, 8'h85})
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    // status read sees the synchronised copy, so hold it three samples
    a_sync_status_map: assert property (
        req_i.rd && !req_i.chan_space && req_i.addr == 8'h84 &&
        status_i == $past(status_i, 1) && status_i == $past(status_i, 2)
        |=> rdata_o == {4'h0, $past(status_i.link_sync[0]),
        $past(status_i.link_sync[1]), $past(status_i.link_sync[2]),
        $past(status_i.link_sync[3])}) else $error("sync status map");

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    a_irq_has_cause: assert property (
        $rose(irq_o) |-> $past(status_i, 4) != '0)
        else $error("irq rose without status");
    a_irq_sticky: assert property (
        $fell(irq_o) |-> $past(req_i.rd, 2))
        else $error("irq fell without read");
endmodule

bind ssirq_top ssirq_top_props u_props (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .status_i(status_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .irq_o(irq_o));

// [testbench/ssirq_top_tb.sv]
// self-checking bench for the status interrupt block
`timescale 1ns/1ns
module ssirq_top_tb;
    logic                     clock_i;
    logic                     arst_n_i;
    ssirq_pkg::ssirq_status_t status_i;
    ssirq_pkg::ssirq_req_t    req_i;
    logic [7:0]               rdata_o;
    logic                     rvalid_o;
    logic                     irq_o;
    int                       err_total = 0;
    int                       n_checks = 0;
    int                       cycles = 0;

    ssirq_top dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .status_i(status_i), .req_i(req_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .irq_o(irq_o));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // 13 sources at roughly 42 cycles each fit well under this
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    task automatic acc(input logic r, input logic sp, input logic [1:0] ch,
                       input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req_i <= '{rd: r, wr: !r, chan_space: sp, chan: ch, addr: a,
                   wdata: d};
        @(posedge clock_i);
        req_i <= '0;
        #1;
    endtask

    task automatic rd(input logic sp, input logic [1:0] ch,
                      input logic [7:0] a, input logic [7:0] exp);
        acc(1'b1, sp, ch, a, 8'h00);
        chk({7'h00, rvalid_o}, 8'h01);
        chk(rdata_o, exp);
    endtask

    task automatic wr(input logic sp, input logic [1:0] ch,
                      input logic [7:0] a, input logic [7:0] d);
        acc(1'b0, sp, ch, a, d);
    endtask

    // one source: index into the packed status vector, lsb first
    task automatic src(input int i);
        logic       sp;
        logic [1:0] ch;
        logic [7:0] m;
        logic [7:0] en;
        logic [7:0] st;
        logic [7:0] lt;
        sp = i < 8;
        ch = 2'(i % 4);
        m  = i < 4 ? 8'h01 : i < 8 ? 8'h02 : i == 8 ? 8'h20 : 8'h08 >> (i - 9);
        en = i < 8 ? 8'h0a : i == 8 ? 8'h0c : 8'h1c;
        st = i < 8 ? 8'h85 : i == 8 ? 8'h82 : 8'h84;
        lt = i < 8 ? 8'h8a : i == 8 ? 8'h83 : 8'h85;
        @(posedge clock_i);
        status_i <= ssirq_pkg::ssirq_status_t'(13'h0001 << i);
        repeat (6) @(posedge clock_i);
        rd(sp, ch, st, m);
        rd(sp, ch, lt, 8'h00);
        wr(sp, ch, en, m);
        rd(sp, ch, en, m);
        repeat (6) @(posedge clock_i);
        #1;
        chk({7'h00, irq_o}, 8'h01);
        rd(sp, ch, lt, m);
        rd(sp, ch, lt, m);
        if (sp) begin
            rd(sp, ch + 2'd1, lt, 8'h00);
        end
        @(posedge clock_i);
        status_i <= '0;
        repeat (6) @(posedge clock_i);
        rd(sp, ch, lt, m);
        rd(sp, ch, lt, 8'h00);
        repeat (2) @(posedge clock_i);
        #1;
        chk({7'h00, irq_o}, 8'h00);
        wr(sp, ch, en, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        arst_n_i = 1'b0;
        status_i = '0;
        req_i = '0;
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(1'b0, 2'd0, 8'h1c, 8'h00);
        rd(1'b0, 2'd0, 8'h0c, 8'h00);
        rd(1'b1, 2'd3, 8'h0a, 8'h00);
        rd(1'b0, 2'd0, 8'h00, 8'h00);
        wr(1'b0, 2'd0, 8'h84, 8'hff);
        wr(1'b0, 2'd0, 8'h85, 8'hff);
        rd(1'b0, 2'd0, 8'h84, 8'h00);
        rd(1'b0, 2'd0, 8'h85, 8'h00);
        for (int i = 0; i < 13; i++) begin
            src(i);
        end
        // mid-run reset must drop enables, latches and the request
        wr(1'b0, 2'd0, 8'h1c, 8'h08);
        @(posedge clock_i);
        status_i <= ssirq_pkg::ssirq_status_t'(13'h0200);
        repeat (6) @(posedge clock_i);
        #1;
        chk({7'h00, irq_o}, 8'h01);
        @(posedge clock_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(1'b0, 2'd0, 8'h1c, 8'h00);
        rd(1'b0, 2'd0, 8'h85, 8'h00);
        repeat (4) @(posedge clock_i);
        #1;
        chk({7'h00, irq_o}, 8'h00);
        @(posedge clock_i);
        status_i <= '0;
        tally_and_finish();
    end
endmodule
